/* addr_decode_pkg.sv */
// Shared constants for the host/PCI address decoder.
// Assumes 36-bit host addresses, 16-bit I/O space, 64-bit PCI addresses.
package addr_decode_pkg;

    // Bridge role in the system
    typedef enum logic [1:0] {
        ROLE_SINGLE = 2'b00,
        ROLE_COMPAT = 2'b01,
        ROLE_AUX    = 2'b10
    } bridge_role_t;

    // Configuration register offsets
    localparam logic [7:0]  REG_ALIAS_MODE       = 8'h48;
    localparam logic [7:0]  REG_BOOT_FW          = 8'h49;
    localparam logic [7:0]  ALIAS_MODE_RESET     = 8'h00;
    localparam int          ALIAS_EN_BIT         = 0;
    localparam int          BOOT_FW_EN_BIT       = 0;

    // Host I/O ports owned by the bridge
    localparam logic [15:0] CFG_ADDR_PORT        = 16'h0CF8;
    localparam logic [15:0] RESET_CTRL_PORT      = 16'h0CF9;
    localparam logic [13:0] CFG_DATA_DWORD       = 14'h033F;
    localparam int          CFG_SPACE_EN_BIT     = 31;

    // ISA expansion alias window
    localparam logic [15:0] ALIAS_LOW            = 16'h0100;
    localparam logic [15:0] ALIAS_HIGH           = 16'h03FF;
    localparam logic [15:0] ALIAS_SPAN_MASK      = 16'h03FF;

    // Fixed legacy memory regions
    localparam logic [18:0] VIDEO_BLOCK_128K     = 19'h00005;
    localparam logic [17:0] LEGACY_BLOCK_256K    = 18'h00003;
    localparam logic [19:0] BOOT_FW_BLOCK_64K    = 20'h0000F;
    localparam int          LEGACY_REGIONS       = 12;

    // Window geometry
    localparam int          MB_SHIFT             = 20;
    localparam logic [2:0]  MAX_SIZE_SEL         = 3'h5;
    localparam logic [3:0]  FB_LIMIT_GB          = 4'h0;
    localparam int          MGMT_STEP_SHIFT      = 16;
    localparam int          IO_SPACE_BITS        = 16;
    localparam int          HOST_ADDR_BITS       = 36;

endpackage

/* io_alias_fold.sv */
// Folds ISA expansion aliases of host or PCI I/O addresses onto 100-3FFh.
// Assumes the caller masks the enable from its mode register.
`timescale 1ns/1ps
module io_alias_fold (
    // Control
    input  wire logic        i_enable,
    // Address
    input  wire logic [15:0] i_addr,
    output logic      [15:0] o_addr
);

    logic [15:0] low_bits;

    // Cards decoding only ten bits see every alias as its base
    always_comb begin
        low_bits = i_addr & addr_decode_pkg::ALIAS_SPAN_MASK;
        if (i_enable && (i_addr > addr_decode_pkg::ALIAS_HIGH) &&
            (low_bits >= addr_decode_pkg::ALIAS_LOW)) begin
            o_addr = low_bits;
        end else begin
            o_addr = i_addr;
        end
    end

endmodule

/* mgmt_ack_tracker.sv */
// Tracks the management interrupt acknowledge level and response.
// Assumes one-cycle transaction strobes on the host clock.
`timescale 1ns/1ps
module mgmt_ack_tracker (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    // Transaction
    input  wire logic i_enable,
    input  wire logic i_ack_cycle,
    input  wire logic i_mode_request_n,
    // Outputs
    output logic      o_response,
    output logic      o_ack_n
);

    logic next_response;
    logic next_ack_n;

    // Level is held until an enabled acknowledge cycle loads the mode request level
    always_comb begin
        next_response = i_enable && i_ack_cycle;
        next_ack_n    = o_ack_n;
        if (i_enable && i_ack_cycle) begin
            next_ack_n = i_mode_request_n;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_response <= 1'b0;
            o_ack_n    <= 1'b1;
        end else begin
            o_response <= next_response;
            o_ack_n    <= next_ack_n;
        end
    end

endmodule

/* host_pci_address_decoder.sv */
// Address decode and routing for a host-to-PCI bridge.
// Assumes one-cycle request strobes on i_ref_clk,
// and window settings held stable.
`timescale 1ns/1ps
module host_pci_address_decoder (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    // Role straps
    input  wire logic [1:0]  i_role,
    // Host request phase
    input  wire logic        i_host_req,
    input  wire logic [35:0] i_host_addr,
    input  wire logic        i_host_addr_wide,
    input  wire logic        i_host_is_io,
    input  wire logic        i_host_write,
    input  wire logic        i_host_full_dword,
    input  wire logic [31:0] i_host_wdata,
    input  wire logic        i_mgmt_mode_request_n,
    input  wire logic        i_host_mgmt_ack_cycle,
    input  wire logic        i_host_timeout,
    // PCI request phase
    input  wire logic        i_pci_req,
    input  wire logic [63:0] i_pci_addr,
    input  wire logic        i_pci_is_io,
    input  wire logic        i_pci_write,
    // Memory windows
    input  wire logic [15:0] i_top_of_memory_mb,
    input  wire logic        i_top_of_memory_forward,
    input  wire logic        i_video_window_enable,
    input  wire logic [23:0] i_legacy_region_attribute_map,
    input  wire logic        i_memory_gap_enable,
    input  wire logic [15:0] i_memory_gap_range_mb,
    input  wire logic [2:0]  i_memory_gap_size_sel,
    input  wire logic        i_high_gap_enable,
    input  wire logic [15:0] i_high_gap_start,
    input  wire logic [15:0] i_high_gap_end,
    input  wire logic        i_frame_buffer_enable,
    input  wire logic [11:0] i_frame_buffer_window_mb,
    input  wire logic [2:0]  i_frame_buffer_size_sel,
    input  wire logic        i_mgmt_ram_enable,
    input  wire logic [19:0] i_mgmt_ram_range_base,
    input  wire logic [3:0]  i_mgmt_ram_range_size,
    // I/O forwarding ranges
    input  wire logic [1:0]  i_io_forward_range_enable,
    input  wire logic [31:0] i_io_forward_range_base,
    input  wire logic [31:0] i_io_forward_range_limit,
    // Configuration register port
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_offset,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    // Host decision
    output logic             o_host_dec_valid,
    output logic             o_host_claim,
    output logic             o_host_forward,
    output logic             o_host_retire,
    output logic             o_cfg_space_enable,
    // PCI decision
    output logic             o_pci_dec_valid,
    output logic             o_pci_forward,
    // Management mode
    output logic             o_mgmt_response,
    output logic             o_mgmt_interrupt_ack_n
);

    addr_decode_pkg::bridge_role_t role;
    logic        is_single;
    logic        is_aux;
    logic        default_resp;

    // Register state
    logic [7:0]  isa_alias_decode_mode;
    logic        boot_fw_enable;
    logic        boot_fw_loaded;
    logic [7:0]  next_isa_alias_decode_mode;
    logic        next_boot_fw_enable;
    logic        next_boot_fw_loaded;
    logic [7:0]  next_reg_rdata;
    logic        next_cfg_space_enable;

    // Decision state
    logic        next_host_dec_valid;
    logic        next_host_claim;
    logic        next_host_forward;
    logic        next_host_retire;
    logic        next_pci_dec_valid;
    logic        next_pci_forward;

    // Decode intermediates
    logic [15:0] host_io_folded;
    logic [15:0] pci_io_folded;
    logic        host_window_hit;
    logic        host_in_mgmt;
    logic        host_above_top;
    logic        cfg_addr_hit;
    logic        cfg_data_hit;
    logic        reset_port_hit;
    logic        own_port_hit;
    logic        host_io_range_hit;
    logic        pci_window_hit;
    logic        pci_above_top;
    logic        pci_io_range_hit;

    always_comb begin
        role = addr_decode_pkg::bridge_role_t'(i_role);
    end

    assign is_single    = (role == addr_decode_pkg::ROLE_SINGLE);
    assign is_aux       = (role == addr_decode_pkg::ROLE_AUX);
    assign default_resp = !is_aux;

    // Power-of-two MB window compare
    function automatic logic size_match(input logic [15:0] addr_mb, input logic [15:0] base_mb,
                                        input logic [2:0] sel);
        logic [15:0] mask;
        mask = 16'hFFFF << sel;
        size_match = (sel <= addr_decode_pkg::MAX_SIZE_SEL) && ((addr_mb & mask) == (base_mb & mask));
    endfunction

    // Memory windows, both directions
    function automatic logic window_hit(input logic [35:0] addr, input logic write,
                                        input logic video_en, input logic [23:0] attr_map,
                                        input logic boot_en, input logic gap_en,
                                        input logic [15:0] gap_base, input logic [2:0] gap_sel,
                                        input logic hgap_en, input logic [15:0] hgap_start,
                                        input logic [15:0] hgap_end, input logic fb_en,
                                        input logic [11:0] fb_base, input logic [2:0] fb_sel);
        logic [15:0] addr_mb;
        logic [3:0]  region;
        logic [1:0]  attr;
        logic        legacy;
        addr_mb = addr[35:addr_decode_pkg::MB_SHIFT];
        region  = addr[17:14];
        attr    = 2'h0;
        legacy  = (addr[35:18] == addr_decode_pkg::LEGACY_BLOCK_256K) && (region < 4'hC);
        if (legacy) begin
            attr = attr_map[region*2 +: 2];
        end
        window_hit = (video_en && (addr[35:17] == addr_decode_pkg::VIDEO_BLOCK_128K))
                   || (legacy && (write ? attr[1] : attr[0]))
                   || (boot_en && (addr[35:16] == addr_decode_pkg::BOOT_FW_BLOCK_64K))
                   || (gap_en && (gap_base != 16'h0000) && size_match(addr_mb, gap_base, gap_sel))
                   || (hgap_en && (addr_mb >= hgap_start) && (addr_mb <= hgap_end))
                   || (fb_en && (addr[35:32] == addr_decode_pkg::FB_LIMIT_GB) &&
                       size_match(addr_mb, {4'h0, fb_base}, fb_sel));
    endfunction

    // Both I/O ranges
    function automatic logic io_range(input logic [15:0] addr, input logic [1:0] en,
                                      input logic [31:0] base, input logic [31:0] limit);
        io_range = 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (en[i] && (addr >= base[i*16 +: 16]) && (addr <= limit[i*16 +: 16])) begin
                io_range = 1'b1;
            end
        end
    endfunction

    // Alias folding ahead of range checks
    io_alias_fold u_host_fold (
        .i_enable (isa_alias_decode_mode[addr_decode_pkg::ALIAS_EN_BIT]),
        .i_addr   (i_host_addr[15:0]),
        .o_addr   (host_io_folded)
    );

    io_alias_fold u_pci_fold (
        .i_enable (isa_alias_decode_mode[addr_decode_pkg::ALIAS_EN_BIT]),
        .i_addr   (i_pci_addr[15:0]),
        .o_addr   (pci_io_folded)
    );

    // Management ack, compatibility end only
    mgmt_ack_tracker u_mgmt_ack (
        .i_ref_clk        (i_ref_clk),
        .i_rstn           (i_rstn),
        .i_enable         (role == addr_decode_pkg::ROLE_COMPAT),
        .i_ack_cycle      (i_host_mgmt_ack_cycle),
        .i_mode_request_n (i_mgmt_mode_request_n),
        .o_response       (o_mgmt_response),
        .o_ack_n          (o_mgmt_interrupt_ack_n)
    );

    // Host-side memory and port decode
    always_comb begin
        host_window_hit = window_hit(i_host_addr, i_host_write, i_video_window_enable,
                                     i_legacy_region_attribute_map, boot_fw_enable,
                                     i_memory_gap_enable, i_memory_gap_range_mb, i_memory_gap_size_sel,
                                     i_high_gap_enable, i_high_gap_start, i_high_gap_end,
                                     i_frame_buffer_enable, i_frame_buffer_window_mb,
                                     i_frame_buffer_size_sel);
        host_in_mgmt    = i_mgmt_ram_enable &&
                          (i_host_addr[35:addr_decode_pkg::MGMT_STEP_SHIFT] >= i_mgmt_ram_range_base) &&
                          ({1'b0, i_host_addr[35:addr_decode_pkg::MGMT_STEP_SHIFT]} <=
                           ({1'b0, i_mgmt_ram_range_base} + {17'h00000, i_mgmt_ram_range_size}));
        host_above_top  = i_host_addr[35:addr_decode_pkg::MB_SHIFT] >= i_top_of_memory_mb;
        cfg_addr_hit    = (i_host_addr[15:0] == addr_decode_pkg::CFG_ADDR_PORT) && i_host_full_dword;
        cfg_data_hit    = (i_host_addr[15:2] == addr_decode_pkg::CFG_DATA_DWORD) && o_cfg_space_enable;
        reset_port_hit  = !is_aux && (i_host_addr[15:0] == addr_decode_pkg::RESET_CTRL_PORT) &&
                          !i_host_full_dword;
        own_port_hit    = cfg_addr_hit || cfg_data_hit || reset_port_hit;
        host_io_range_hit = io_range(host_io_folded, i_io_forward_range_enable,
                                     i_io_forward_range_base, i_io_forward_range_limit);
    end

    // PCI-side decode with the same windows
    always_comb begin
        pci_window_hit   = window_hit(i_pci_addr[35:0], i_pci_write, i_video_window_enable,
                                      i_legacy_region_attribute_map, boot_fw_enable,
                                      i_memory_gap_enable, i_memory_gap_range_mb, i_memory_gap_size_sel,
                                      i_high_gap_enable, i_high_gap_start, i_high_gap_end,
                                      i_frame_buffer_enable, i_frame_buffer_window_mb,
                                      i_frame_buffer_size_sel);
        pci_above_top    = i_pci_addr[35:addr_decode_pkg::MB_SHIFT] >= i_top_of_memory_mb;
        pci_io_range_hit = io_range(pci_io_folded, i_io_forward_range_enable,
                                    i_io_forward_range_base, i_io_forward_range_limit);
    end

    // Host decision, one per request strobe
    always_comb begin
        next_host_dec_valid = i_host_req;
        next_host_claim     = 1'b0;
        next_host_forward   = 1'b0;
        next_host_retire    = i_host_timeout && default_resp;
        if (i_host_req && !i_host_addr_wide) begin
            if (i_host_is_io) begin
                if (own_port_hit) begin
                    next_host_claim = 1'b1;
                end else if (is_single) begin
                    next_host_forward = 1'b1;
                end else if (is_aux) begin
                    next_host_forward = host_io_range_hit;
                end else begin
                    next_host_forward = !host_io_range_hit;
                end
            end else if (host_in_mgmt) begin
                next_host_forward = i_mgmt_mode_request_n;
            end else if (host_window_hit) begin
                next_host_forward = 1'b1;
            end else if (host_above_top) begin
                next_host_forward = default_resp && i_top_of_memory_forward;
            end else begin
                next_host_forward = 1'b0;
            end
            next_host_claim = next_host_claim || next_host_forward;
        end
        // Timed-out work is dropped, so nothing from it reaches PCI
        if (i_host_timeout) begin
            next_host_forward = 1'b0;
        end
    end

    // PCI decision, one per request strobe
    always_comb begin
        next_pci_dec_valid = i_pci_req;
        next_pci_forward   = 1'b0;
        if (i_pci_req) begin
            if (i_pci_is_io) begin
                if (i_pci_addr[63:addr_decode_pkg::IO_SPACE_BITS] != 48'h0) begin
                    next_pci_forward = 1'b0;
                end else if (is_single) begin
                    next_pci_forward = 1'b0;
                end else if (is_aux) begin
                    next_pci_forward = !pci_io_range_hit;
                end else begin
                    next_pci_forward = pci_io_range_hit;
                end
            end else if (i_pci_addr[63:addr_decode_pkg::HOST_ADDR_BITS] != 28'h0) begin
                next_pci_forward = 1'b0;
            end else if (pci_window_hit) begin
                next_pci_forward = 1'b0;
            end else if (pci_above_top) begin
                next_pci_forward = !(default_resp && i_top_of_memory_forward);
            end else begin
                next_pci_forward = 1'b1;
            end
        end
    end

    // Config registers and config-space enable
    always_comb begin
        next_isa_alias_decode_mode = isa_alias_decode_mode;
        next_boot_fw_enable        = boot_fw_enable;
        next_boot_fw_loaded        = 1'b1;
        next_cfg_space_enable      = o_cfg_space_enable;
        if (!boot_fw_loaded) begin
            next_boot_fw_enable = !is_aux;
        end
        if (i_reg_wr) begin
            case (i_reg_offset)
                addr_decode_pkg::REG_ALIAS_MODE: next_isa_alias_decode_mode = i_reg_wdata;
                addr_decode_pkg::REG_BOOT_FW:    next_boot_fw_enable = i_reg_wdata[addr_decode_pkg::BOOT_FW_EN_BIT];
                default:                         next_isa_alias_decode_mode = isa_alias_decode_mode;
            endcase
        end
        if (i_host_req && i_host_is_io && i_host_write && cfg_addr_hit && !i_host_addr_wide) begin
            next_cfg_space_enable = i_host_wdata[addr_decode_pkg::CFG_SPACE_EN_BIT];
        end
        case (i_reg_offset)
            addr_decode_pkg::REG_ALIAS_MODE: next_reg_rdata = isa_alias_decode_mode;
            addr_decode_pkg::REG_BOOT_FW:    next_reg_rdata = {7'h00, boot_fw_enable};
            default:                         next_reg_rdata = 8'h00;
        endcase
    end

    // Role is sampled by the loader after reset, not under reset
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            isa_alias_decode_mode <= addr_decode_pkg::ALIAS_MODE_RESET;
            boot_fw_enable        <= 1'b0;
            boot_fw_loaded        <= 1'b0;
            o_cfg_space_enable    <= 1'b0;
            o_reg_rdata           <= 8'h00;
        end else begin
            isa_alias_decode_mode <= next_isa_alias_decode_mode;
            boot_fw_enable        <= next_boot_fw_enable;
            boot_fw_loaded        <= next_boot_fw_loaded;
            o_cfg_space_enable    <= next_cfg_space_enable;
            o_reg_rdata           <= next_reg_rdata;
        end
    end

    // Decisions, one cycle after the request
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_host_dec_valid <= 1'b0;
            o_host_claim     <= 1'b0;
            o_host_forward   <= 1'b0;
            o_host_retire    <= 1'b0;
            o_pci_dec_valid  <= 1'b0;
            o_pci_forward    <= 1'b0;
        end else begin
            o_host_dec_valid <= next_host_dec_valid;
            o_host_claim     <= next_host_claim;
            o_host_forward   <= next_host_forward;
            o_host_retire    <= next_host_retire;
            o_pci_dec_valid  <= next_pci_dec_valid;
            o_pci_forward    <= next_pci_forward;
        end
    end

endmodule

/* host_pci_address_decoder_properties.sv */
// Port timing checker for the decoder, bound to its top module.
// Assumes one clock domain with an active-low async reset.
`timescale 1ns/1ps
module host_pci_address_decoder_properties (
    input wire logic        i_ref_clk, i_rstn, i_host_req, i_host_addr_wide, i_host_timeout,
    input wire logic        i_pci_req, i_pci_is_io, i_host_mgmt_ack_cycle, i_mgmt_mode_request_n,
    input wire logic [1:0]  i_role,
    input wire logic [63:0] i_pci_addr,
    input wire logic        o_host_dec_valid, o_host_claim, o_host_forward, o_pci_dec_valid,
    input wire logic        o_pci_forward, o_mgmt_response, o_mgmt_interrupt_ack_n
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // One decision per request, exactly one cycle later
    AST_HOST_ANSWER: assert property (i_host_req |=> o_host_dec_valid) else $error("no host answer");
    AST_HOST_QUIET: assert property (!i_host_req |=> !o_host_dec_valid && !o_host_claim)
        else $error("stray host answer");
    AST_PCI_ANSWER: assert property (i_pci_req |=> o_pci_dec_valid) else $error("no pci answer");
    // Refused and retired requests are never forwarded
    AST_WIDE: assert property (i_host_req && i_host_addr_wide |=> !o_host_claim) else $error("wide claimed");
    AST_TIMEOUT: assert property (i_host_req && i_host_timeout |=> !o_host_forward) else $error("timeout sent");
    AST_FWD_CLAIM: assert property (o_host_forward |-> o_host_claim) else $error("forward unclaimed");
    AST_PCI_IO: assert property (i_pci_req && i_pci_is_io && (i_role == 2'b00 || |i_pci_addr[63:16])
        |=> !o_pci_forward) else $error("pci io sent");
    // Acknowledge level only moves on an acknowledge cycle
    AST_ACK_HOLD: assert property (!$past(i_host_mgmt_ack_cycle) |-> $stable(o_mgmt_interrupt_ack_n))
        else $error("ack moved");
    AST_ACK_SET: assert property (i_host_mgmt_ack_cycle && i_role == 2'b01 |=> o_mgmt_response
        && o_mgmt_interrupt_ack_n == $past(i_mgmt_mode_request_n)) else $error("ack wrong");
    cover property (o_host_forward);
    cover property (o_pci_forward);
    cover property (o_mgmt_response && !o_mgmt_interrupt_ack_n);
endmodule
bind host_pci_address_decoder host_pci_address_decoder_properties host_pci_address_decoder_properties_inst (.*);

/* pci_agent_model.sv */
// PCI agent model issuing one-cycle request phases.
// Assumes the bench commands one request at a time.
`timescale 1ns/1ps
module pci_agent_model (
    input  wire logic        i_ref_clk, i_go, i_is_io,
    input  wire logic [63:0] i_addr,
    output logic             o_req, o_is_io,
    output logic [63:0]      o_addr
);
    // Released lines invert so a stale address never looks valid
    always_ff @(posedge i_ref_clk) begin
        o_req <= i_go;
        o_is_io <= i_go ? i_is_io : ~o_is_io;
        o_addr <= i_go ? i_addr : ~o_addr;
    end
endmodule

/* host_pci_address_decoder_test.sv */
// Self-checking bench for the host/PCI address decoder.
// Assumes the PCI agent model on the PCI side.
`timescale 1ns/1ps
module host_pci_address_decoder_test;
    logic i_ref_clk, i_rstn, i_host_req, i_host_addr_wide, i_host_is_io, i_host_write, i_host_full_dword;
    logic i_mgmt_mode_request_n, i_host_mgmt_ack_cycle, i_host_timeout, i_pci_req, i_pci_is_io, i_pci_write;
    logic i_top_of_memory_forward, i_video_window_enable, i_memory_gap_enable, i_high_gap_enable;
    logic i_frame_buffer_enable, i_mgmt_ram_enable, i_reg_wr, go, gio;
    logic o_host_dec_valid, o_host_claim, o_host_forward, o_host_retire, o_cfg_space_enable;
    logic o_pci_dec_valid, o_pci_forward, o_mgmt_response, o_mgmt_interrupt_ack_n;
    logic [1:0]  i_role, i_io_forward_range_enable;
    logic [2:0]  i_memory_gap_size_sel, i_frame_buffer_size_sel;
    logic [3:0]  i_mgmt_ram_range_size;
    logic [7:0]  i_reg_offset, i_reg_wdata, o_reg_rdata;
    logic [11:0] i_frame_buffer_window_mb;
    logic [15:0] i_top_of_memory_mb, i_memory_gap_range_mb, i_high_gap_start, i_high_gap_end;
    logic [19:0] i_mgmt_ram_range_base;
    logic [23:0] i_legacy_region_attribute_map;
    logic [31:0] i_host_wdata, i_io_forward_range_base, i_io_forward_range_limit;
    logic [35:0] i_host_addr, a;
    logic [63:0] i_pci_addr, ga, pa;
    int          err_count, compares;
    host_pci_address_decoder host_pci_address_decoder_inst (.*);
    pci_agent_model pci_agent_model_inst (.i_ref_clk, .i_go(go), .i_is_io(gio), .i_addr(ga),
        .o_req(i_pci_req), .o_is_io(i_pci_is_io), .o_addr(i_pci_addr));
    // Free-running clock
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    task automatic chk(input logic [63:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Host request, answer checked 1 ns after the taking edge
    task automatic host(input logic [35:0] ad, input logic io, dw, w, t, input logic [1:0] e);
        @(posedge i_ref_clk);
        {i_host_req, i_host_addr, i_host_is_io, i_host_full_dword, i_host_addr_wide, i_host_timeout} <= {1'b1, ad, io, dw, w, t};
        @(posedge i_ref_clk);
        {i_host_req, i_host_timeout} <= 2'b00;
        #1 chk({o_host_dec_valid, o_host_claim, o_host_forward, o_host_retire}, {1'b1, e, t});
    endtask
    task automatic pci(input logic [63:0] ad, input logic io, e);
        @(posedge i_ref_clk);
        {go, ga, gio} <= {1'b1, ad, io};
        @(posedge i_ref_clk);
        go <= 1'b0;
        @(posedge i_ref_clk);
        #1 chk({o_pci_dec_valid, o_pci_forward}, {1'b1, e});
    endtask
    task automatic reg_io(input logic w, input logic [7:0] off, d);
        @(posedge i_ref_clk);
        {i_reg_wr, i_reg_offset, i_reg_wdata} <= {w, off, d};
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
        #1 if (!w) chk(o_reg_rdata, d);
    endtask
    task automatic rst(input logic [1:0] r);
        @(posedge i_ref_clk);
        {i_rstn, i_role} <= {1'b0, r};
        repeat (16) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
    endtask
    // Expected: management range, frame buffer, top of memory
    function automatic logic [1:0] exp_host(input logic [35:0] ad);
        if (ad[35:16] == i_mgmt_ram_range_base) return {2{i_mgmt_mode_request_n}};
        if (ad[35:20] == {4'h0, i_frame_buffer_window_mb}) return 2'b11;
        return {2{ad[35:20] >= i_top_of_memory_mb && i_top_of_memory_forward}};
    endfunction
    function automatic logic exp_pci(input logic [63:0] ad);
        return ad[63:36] == 0 && ad[35:20] != {4'h0, i_frame_buffer_window_mb} && ad[35:20] < i_top_of_memory_mb;
    endfunction
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        err_count++;
        test_done;
    end
    // Main sequence
    initial begin
        void'($urandom(8010));
        {i_host_req, i_host_addr_wide, i_host_is_io, i_host_full_dword, i_host_mgmt_ack_cycle, i_host_timeout} = '0;
        {i_pci_write, i_reg_wr, go, gio, i_video_window_enable, i_memory_gap_enable, i_high_gap_enable, i_rstn} = '0;
        {i_host_write, i_mgmt_mode_request_n, i_top_of_memory_forward, i_frame_buffer_enable, i_mgmt_ram_enable} = '1;
        {i_memory_gap_range_mb, i_memory_gap_size_sel, i_high_gap_start, i_high_gap_end, i_frame_buffer_size_sel} = '0;
        {i_mgmt_ram_range_size, i_legacy_region_attribute_map, i_host_addr, ga, i_reg_offset, i_reg_wdata} = '0;
        {i_role, i_io_forward_range_enable, i_host_wdata, i_top_of_memory_mb} = {4'h5, 32'h8000_0000, 16'h0100};
        {i_frame_buffer_window_mb, i_mgmt_ram_range_base} = {12'h080, 20'h01800};
        {i_io_forward_range_base, i_io_forward_range_limit} = {32'h0000_0300, 32'h0000_031F};
        rst(2'b01);
        reg_io(0, 8'h48, 8'h00);
        reg_io(0, 8'h50, 8'h00);
        host(36'h0_000F_8000, 0, 1, 0, 0, 2'b11);
        host(36'h0_000A_0000, 0, 1, 0, 0, 2'b00);
        i_video_window_enable <= 1'b1;
        host(36'h0_000A_0000, 0, 1, 0, 0, 2'b11);
        host(36'h0_2000_0000, 0, 1, 1, 0, 2'b00);
        host(36'h0_0010_0000, 0, 1, 0, 1, 2'b00);
        i_mgmt_mode_request_n <= 1'b0;
        host(36'h0_1800_0000, 0, 1, 0, 0, 2'b00);
        i_mgmt_mode_request_n <= 1'b1;
        host(36'h0_1800_0000, 0, 1, 0, 0, 2'b11);
        host(36'h0CFC, 1, 1, 0, 0, 2'b11);
        host(36'h0CF8, 1, 0, 0, 0, 2'b11);
        host(36'h0CF8, 1, 1, 0, 0, 2'b10);
        host(36'h0CFC, 1, 1, 0, 0, 2'b10);
        chk(o_cfg_space_enable, 1);
        host(36'h0CF9, 1, 0, 0, 0, 2'b10);
        host(36'h0300, 1, 1, 0, 0, 2'b00);
        host(36'h0700, 1, 1, 0, 0, 2'b11);
        reg_io(1, 8'h48, 8'h01);
        reg_io(0, 8'h48, 8'h01);
        host(36'h0700, 1, 1, 0, 0, 2'b00);
        pci(64'h0300, 1, 1);
        pci(64'h1_0300, 1, 0);
        pci(64'h0400, 1, 0);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_ref_clk);
            {i_host_mgmt_ack_cycle, i_mgmt_mode_request_n} <= {1'b1, k[0]};
            @(posedge i_ref_clk);
            {i_host_mgmt_ack_cycle, i_mgmt_mode_request_n} <= 2'b01;
            #1 chk({o_mgmt_response, o_mgmt_interrupt_ack_n}, {1'b1, k[0]});
        end
        repeat (24) begin
            a = {16'($urandom_range(511, 1)), 20'($urandom)};
            pa = {28'($urandom_range(3) == 0), 16'($urandom_range(511, 1)), 20'($urandom)};
            host(a, 0, 1, 0, 0, exp_host(a));
            pci(pa, 0, exp_pci(pa));
        end
        rst(2'b10);
        host(36'h0_000F_8000, 0, 1, 0, 0, 2'b00);
        host(36'h0400, 1, 1, 0, 0, 2'b00);
        host(36'h0CF8, 1, 1, 0, 0, 2'b10);
        pci(64'h0400, 1, 1);
        pci(64'h0300, 1, 0);
        rst(2'b00);
        host(36'h0300, 1, 1, 0, 0, 2'b11);
        pci(64'h0300, 1, 0);
        test_done;
    end
endmodule
